// ==== fap_pkg.sv ====
package fap_pkg;
  localparam int NEP = 4;
  localparam int LW = 11;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_LEN_HI [NEP] = '{16'hE620, 16'hE622, 16'hE624, 16'hE626};
  localparam logic [15:0] IDX_LEN_LO [NEP] = '{16'hE621, 16'hE623, 16'hE625, 16'hE627};
  localparam logic [15:0] IDX_PF2_HI = 16'hE630;
  localparam logic [15:0] IDX_PF2_LO = 16'hE631;
  localparam logic [15:0] IDX_PF4_HI = 16'hE632;
  localparam logic [15:0] IDX_PF4_LO = 16'hE633;
  localparam logic [15:0] IDX_CTRL = 16'hE638;
  localparam logic [15:0] IDX_STAT = 16'hE639;
  localparam logic [7:0] RST_LEN_HI = 8'h02;
  localparam logic [7:0] RST_LEN_LO = 8'h00;
  localparam logic [7:0] RST_PF_HI = 8'h88;
  localparam logic [7:0] RST_PF_LO = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] LEN_HI_MASK [NEP] = '{8'h07, 8'h03, 8'h07, 8'h03};
  localparam logic [LW-1:0] MAX_LEN [NEP] = '{11'h400, 11'h200, 11'h400, 11'h200};
  localparam logic [7:0] PF2_HI_MASK = 8'hFB;
  localparam logic [7:0] PF4_HI_MASK = 8'hD9;
  localparam logic [7:0] CTRL_MASK = 8'h7F;
  localparam logic [10:0] PF4_MAX = 11'h400;
  // Control bits: auto commit per endpoint in 3..0
  localparam int C_HS = 4;
  localparam int C_IN2 = 5;
  localparam int C_IN4 = 6;
  // Flag register field positions
  localparam int B_FLAG_DECISION_SELECT = 7;
  localparam int B_PKST = 6;
  localparam int PK_HS_MSB = 5;
  localparam int PK_HS_LSB = 3;
  localparam int PK4_MSB = 4;
  localparam int PK_FS_MSB = 7;
  localparam int PK_FS_LSB = 6;
  localparam int FS_LO_MSB = 5;
  localparam int B_C9 = 1;
  localparam int B_C8 = 0;
endpackage

// ==== fap_top.sv ====
// Chosen here: register access over APB.
`timescale 1ns/1ns
module fap_top #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // IN data from the FIFO side
  input wire logic src_valid_in,
  output logic src_ready_out,
  input wire logic [7:0] src_data_in,
  input wire logic [1:0] src_ep_in,
  // Packetised data to the serial engine
  output logic pkt_valid_out,
  input wire logic pkt_ready_in,
  output logic [7:0] pkt_data_out,
  output logic [1:0] pkt_ep_out,
  output logic pkt_last_out,
  // Decoded flag levels
  output logic [2:0] ep2_packet_count_field_out,
  output logic [12:0] ep2_flag_count_field_out,
  output logic [1:0] ep2_select_out,
  output logic [1:0] ep4_packet_count_field_out,
  output logic [10:0] ep4_flag_count_field_out,
  output logic [1:0] ep4_select_out
);
  localparam int NEP = fap_pkg::NEP;
  localparam int LW = fap_pkg::LW;
  localparam int BW = 11;

  logic [7:0] len_hi_ff [NEP];
  logic [7:0] len_lo_ff [NEP];
  logic [7:0] nxt_len_hi [NEP];
  logic [7:0] nxt_len_lo [NEP];
  logic [7:0] pf_hi_ff [2];
  logic [7:0] pf_lo_ff [2];
  logic [7:0] nxt_pf_hi [2];
  logic [7:0] nxt_pf_lo [2];
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [15:0] idx;
  logic wr_go, hit;
  logic [7:0] rd;
  logic [LW-1:0] cnt_ff [NEP];
  logic [LW-1:0] nxt_cnt [NEP];
  logic [LW-1:0] plen [NEP];
  logic [LW-1:0] raw;
  logic push, pop, push_last;
  logic hv_ff, sv_ff, rdy_ff, nxt_hv, nxt_sv, nxt_rdy;
  logic [BW-1:0] hd_ff, sd_ff, nxt_hd, nxt_sd, push_word;
  logic [2:0] p2_ff, nxt_p2;
  logic [12:0] f2_ff, nxt_f2;
  logic [1:0] p4_ff, nxt_p4, s2_ff, s4_ff, nxt_s2, nxt_s4;
  logic [10:0] f4_ff, nxt_f4, f4_raw;
  logic hs, in2, in4;

  assign idx = paddr_in[17:2];
  assign wr_go = psel_in & penable_in & pready_ff & pwrite_in;

  // Effective length: zero or oversize falls back to the endpoint maximum
  always_comb begin
    raw = '0;
    for (int i = 0; i < NEP; i++) begin
      raw = {len_hi_ff[i][2:0], len_lo_ff[i]};
      plen[i] = (raw == '0 || raw > fap_pkg::MAX_LEN[i]) ? fap_pkg::MAX_LEN[i] : raw;
    end
  end

  // Register file next state and read mux
  always_comb begin
    hit = 1'b0;
    rd = 8'h00;
    nxt_ctrl = ctrl_ff;
    for (int i = 0; i < NEP; i++) begin
      nxt_len_hi[i] = len_hi_ff[i];
      nxt_len_lo[i] = len_lo_ff[i];
      if (idx == fap_pkg::IDX_LEN_HI[i]) begin
        hit = 1'b1;
        rd = len_hi_ff[i];
        if (wr_go) nxt_len_hi[i] = pwdata_in[7:0] & fap_pkg::LEN_HI_MASK[i];
      end
      if (idx == fap_pkg::IDX_LEN_LO[i]) begin
        hit = 1'b1;
        rd = len_lo_ff[i];
        if (wr_go) nxt_len_lo[i] = pwdata_in[7:0];
      end
    end
    nxt_pf_hi = pf_hi_ff;
    nxt_pf_lo = pf_lo_ff;
    case (idx)
      fap_pkg::IDX_PF2_HI: begin
        hit = 1'b1;
        rd = pf_hi_ff[0];
        if (wr_go) nxt_pf_hi[0] = pwdata_in[7:0] & fap_pkg::PF2_HI_MASK;
      end
      fap_pkg::IDX_PF2_LO: begin
        hit = 1'b1;
        rd = pf_lo_ff[0];
        if (wr_go) nxt_pf_lo[0] = pwdata_in[7:0];
      end
      fap_pkg::IDX_PF4_HI: begin
        hit = 1'b1;
        rd = pf_hi_ff[1];
        if (wr_go) nxt_pf_hi[1] = pwdata_in[7:0] & fap_pkg::PF4_HI_MASK;
      end
      fap_pkg::IDX_PF4_LO: begin
        hit = 1'b1;
        rd = pf_lo_ff[1];
        if (wr_go) nxt_pf_lo[1] = pwdata_in[7:0];
      end
      fap_pkg::IDX_CTRL: begin
        hit = 1'b1;
        rd = ctrl_ff;
        if (wr_go) nxt_ctrl = pwdata_in[7:0] & fap_pkg::CTRL_MASK;
      end
      fap_pkg::IDX_STAT: begin
        hit = 1'b1;
        rd = {5'h00, rdy_ff, sv_ff, hv_ff};
      end
      default: begin
      end
    endcase
    nxt_pready = psel_in & penable_in & ~pready_ff;
    nxt_prdata = nxt_pready ? {24'h000000, rd} : 32'h00000000;
    nxt_pslverr = nxt_pready & ~hit;
  end

  // Packetiser: counts bytes per endpoint with auto commit on and marks the packet end
  assign push = src_valid_in & rdy_ff;
  assign pop = hv_ff & pkt_ready_in;
  always_comb begin
    push_last = 1'b0;
    nxt_cnt = cnt_ff;
    if (push) begin
      if (ctrl_ff[src_ep_in]) begin
        push_last = (cnt_ff[src_ep_in] + 11'h001) == plen[src_ep_in];
        nxt_cnt[src_ep_in] = push_last ? '0 : cnt_ff[src_ep_in] + 11'h001;
      end else begin
        nxt_cnt[src_ep_in] = '0;
      end
    end
    push_word = {push_last, src_ep_in, src_data_in};
  end

  // Two-entry buffer: head drives the outputs, skid catches a stalled word
  always_comb begin
    nxt_hv = hv_ff;
    nxt_hd = hd_ff;
    nxt_sv = sv_ff;
    nxt_sd = sd_ff;
    if (!hv_ff || pop) begin
      if (sv_ff) begin
        nxt_hd = sd_ff;
        nxt_hv = 1'b1;
        nxt_sv = 1'b0;
      end else begin
        nxt_hd = push ? push_word : hd_ff;
        nxt_hv = push;
      end
    end else if (push) begin
      nxt_sd = push_word;
      nxt_sv = 1'b1;
    end
    nxt_rdy = ~nxt_sv;
  end

  // Flag level decode by speed and direction
  always_comb begin
    hs = ctrl_ff[fap_pkg::C_HS];
    in2 = ctrl_ff[fap_pkg::C_IN2];
    in4 = ctrl_ff[fap_pkg::C_IN4];
    nxt_s2 = {pf_hi_ff[0][fap_pkg::B_FLAG_DECISION_SELECT], pf_hi_ff[0][fap_pkg::B_PKST]};
    nxt_s4 = {pf_hi_ff[1][fap_pkg::B_FLAG_DECISION_SELECT], pf_hi_ff[1][fap_pkg::B_PKST]};
    nxt_p2 = 3'h0;
    nxt_p4 = 2'h0;
    nxt_f2 = {pf_hi_ff[0][fap_pkg::PK_HS_MSB:fap_pkg::PK_HS_LSB],
              pf_hi_ff[0][fap_pkg::B_C9:fap_pkg::B_C8], pf_lo_ff[0]};
    f4_raw = {pf_hi_ff[1][fap_pkg::PK4_MSB:fap_pkg::PK_HS_LSB],
              pf_hi_ff[1][fap_pkg::B_C8], pf_lo_ff[1]};
    if (in2 && hs) begin
      nxt_p2 = pf_hi_ff[0][fap_pkg::PK_HS_MSB:fap_pkg::PK_HS_LSB];
      nxt_f2 = {3'h0, pf_hi_ff[0][fap_pkg::B_C9:fap_pkg::B_C8], pf_lo_ff[0]};
    end else if (in2) begin
      nxt_p2 = {pf_hi_ff[0][fap_pkg::B_C8],
                pf_lo_ff[0][fap_pkg::PK_FS_MSB:fap_pkg::PK_FS_LSB]};
      nxt_f2 = {3'h0, pf_hi_ff[0][fap_pkg::B_C9], 3'h0,
                pf_lo_ff[0][fap_pkg::FS_LO_MSB:0]};
    end
    if (in4 && hs) begin
      nxt_p4 = pf_hi_ff[1][fap_pkg::PK4_MSB:fap_pkg::PK_HS_LSB];
      f4_raw = {2'h0, pf_hi_ff[1][fap_pkg::B_C8], pf_lo_ff[1]};
    end else if (in4) begin
      nxt_p4 = pf_lo_ff[1][fap_pkg::PK_FS_MSB:fap_pkg::PK_FS_LSB];
      f4_raw = {2'h0, pf_hi_ff[1][fap_pkg::B_C8], 2'h0, pf_lo_ff[1][fap_pkg::FS_LO_MSB:0]};
    end
    nxt_f4 = (f4_raw > fap_pkg::PF4_MAX) ? fap_pkg::PF4_MAX : f4_raw;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NEP; i++) begin
        len_hi_ff[i] <= fap_pkg::RST_LEN_HI;
        len_lo_ff[i] <= fap_pkg::RST_LEN_LO;
        cnt_ff[i] <= '0;
      end
      for (int j = 0; j < 2; j++) begin
        pf_hi_ff[j] <= fap_pkg::RST_PF_HI;
        pf_lo_ff[j] <= fap_pkg::RST_PF_LO;
      end
      ctrl_ff <= fap_pkg::RST_CTRL;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      hv_ff <= 1'b0;
      sv_ff <= 1'b0;
      rdy_ff <= 1'b0;
      hd_ff <= '0;
      sd_ff <= '0;
      p2_ff <= 3'h0;
      f2_ff <= 13'h0000;
      p4_ff <= 2'h0;
      f4_ff <= 11'h000;
      s2_ff <= 2'h0;
      s4_ff <= 2'h0;
    end else begin
      len_hi_ff <= nxt_len_hi;
      len_lo_ff <= nxt_len_lo;
      cnt_ff <= nxt_cnt;
      pf_hi_ff <= nxt_pf_hi;
      pf_lo_ff <= nxt_pf_lo;
      ctrl_ff <= nxt_ctrl;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      hv_ff <= nxt_hv;
      sv_ff <= nxt_sv;
      rdy_ff <= nxt_rdy;
      hd_ff <= nxt_hd;
      sd_ff <= nxt_sd;
      p2_ff <= nxt_p2;
      f2_ff <= nxt_f2;
      p4_ff <= nxt_p4;
      f4_ff <= nxt_f4;
      s2_ff <= nxt_s2;
      s4_ff <= nxt_s4;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign src_ready_out = rdy_ff;
  assign pkt_valid_out = hv_ff;
  assign pkt_data_out = hd_ff[7:0];
  assign pkt_ep_out = hd_ff[9:8];
  assign pkt_last_out = hd_ff[10];
  assign ep2_packet_count_field_out = p2_ff;
  assign ep2_flag_count_field_out = f2_ff;
  assign ep2_select_out = s2_ff;
  assign ep4_packet_count_field_out = p4_ff;
  assign ep4_flag_count_field_out = f4_ff;
  assign ep4_select_out = s4_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  len_reset_a: assert property ($rose(rst_n_in) |-> len_hi_ff[1] == 8'h02 && len_lo_ff[1] == 8'h00)
    else $error("packet length not 512 after reset");
  auto_cut_a: assert property (push && ctrl_ff[src_ep_in] && push_last |=> cnt_ff[$past(src_ep_in)] == '0)
    else $error("byte counter not cleared at packet end");
  manual_hold_a: assert property (push && !ctrl_ff[src_ep_in] |=> !(sv_ff && sd_ff[10]))
    else $error("packet end set with auto commit off");
  len_cap_a: assert property (plen[1] <= 11'h200 && plen[3] <= 11'h200 && plen[0] <= 11'h400)
    else $error("packet length above endpoint maximum");
  pf_bit2_a: assert property (pf_hi_ff[0][2] == 1'b0)
    else $error("flag high bit 2 not zero");
  pf_reset_a: assert property ($rose(rst_n_in) |-> pf_hi_ff[0] == fap_pkg::RST_PF_HI)
    else $error("flag high reset value wrong");
  hs_count_a: assert property (hs && in2 |=> p2_ff == $past(pf_hi_ff[0][5:3]))
    else $error("high speed packet count misplaced");
  fs_count_a: assert property (!hs && in2 |=> p2_ff == {$past(pf_hi_ff[0][0]), $past(pf_lo_ff[0][7:6])})
    else $error("full speed packet count misplaced");
  ep4_max_a: assert property (f4_ff <= 11'h400)
    else $error("endpoint 4 level above 1024");
  apb_answer_a: assert property (psel_in && penable_in && !pready_ff |=> pready_ff)
    else $error("no answer in second access cycle");
  stall_hold_a: assert property (pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_data_out))
    else $error("word lost under stall");
  packet_end_c: cover property (pkt_valid_out && pkt_ready_in && pkt_last_out);
  skid_full_c: cover property (sv_ff && !src_ready_out);
  reg_write_c: cover property (wr_go && idx == fap_pkg::IDX_CTRL);
  bad_addr_c: cover property (pslverr_out);
endmodule

// ==== fap_sink.sv ====
`timescale 1ns/1ns
module fap_sink (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Packet stream from the block
  input wire logic valid_in,
  input wire logic last_in,
  input wire logic [7:0] data_in,
  input wire logic [1:0] ep_in,
  output logic ready_out,
  // Control and tallies
  input wire logic slow_in,
  output int beats_out,
  output int lasts_out,
  output logic [7:0] end_byte_out,
  output logic [1:0] ep_out
);
  logic [1:0] ph_ff;
  // Slow mode accepts one cycle in four so the skid buffer fills
  assign ready_out = !slow_in || (ph_ff == 2'h3);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ph_ff <= 2'h0;
      beats_out <= 0;
      lasts_out <= 0;
      end_byte_out <= 8'h00;
      ep_out <= 2'h0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      if (valid_in && ready_out) begin
        beats_out <= beats_out + 1;
        lasts_out <= lasts_out + int'(last_in);
        ep_out <= ep_in;
        // Byte that closed the most recent packet
        if (last_in) begin
          end_byte_out <= data_in;
        end
      end
    end
  end
endmodule

// ==== test_fap_top.sv ====
`timescale 1ns/1ns
module test_fap_top;
  logic ref_clk_in, rst_n_in, psel, pen, pwr, pready, pslverr, sv, srdy, pv, prdy, plast, slow;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] sdata, pdata, end_byte;
  logic [1:0] pep, last_ep;
  logic [1:0] sep, ep2_sel, ep4_sel, ep4_pk;
  logic [2:0] ep2_pk;
  logic [12:0] ep2_cnt;
  logic [10:0] ep4_cnt;
  logic err;
  int beats, lasts, error_cnt, num_checks;
  fap_top u_fap_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .src_valid_in(sv),
    .src_ready_out(srdy), .src_data_in(sdata), .src_ep_in(sep), .pkt_valid_out(pv),
    .pkt_ready_in(prdy), .pkt_data_out(pdata), .pkt_ep_out(pep), .pkt_last_out(plast),
    .ep2_packet_count_field_out(ep2_pk), .ep2_flag_count_field_out(ep2_cnt),
    .ep2_select_out(ep2_sel), .ep4_packet_count_field_out(ep4_pk),
    .ep4_flag_count_field_out(ep4_cnt), .ep4_select_out(ep4_sel));
  fap_sink u_fap_sink (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .valid_in(pv),
    .last_in(plast), .data_in(pdata), .ep_in(pep), .ready_out(prdy), .slow_in(slow),
    .beats_out(beats), .lasts_out(lasts), .end_byte_out(end_byte), .ep_out(last_ep));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk_in);
    pen <= 1'b1;
    // Request stands until the rising edge at which pready is seen high
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task send(input logic [1:0] ep, input int n, input int expect_beats);
    for (int i = 0; i < n; i++) begin
      sv <= 1'b1;
      sep <= ep;
      sdata <= 8'(i);
      do @(posedge ref_clk_in); while (srdy !== 1'b1);
    end
    sv <= 1'b0;
    while (beats < expect_beats) @(posedge ref_clk_in);
  endtask
  task test_reset_map;
    for (int i = 0; i < fap_pkg::NEP; i++) begin
      apb(1'b0, fap_pkg::IDX_LEN_HI[i], 8'h00);
      chk("len_hi_rst", rd, 32'h00000002);
      apb(1'b0, fap_pkg::IDX_LEN_LO[i], 8'h00);
      chk("len_lo_rst", rd, 32'h00000000);
      apb(1'b1, fap_pkg::IDX_LEN_HI[i], 8'hFF);
      apb(1'b0, fap_pkg::IDX_LEN_HI[i], 8'h00);
      chk("len_hi_width", rd, i[0] ? 32'h00000003 : 32'h00000007);
    end
    apb(1'b0, fap_pkg::IDX_PF2_HI, 8'h00);
    chk("pf2_hi_rst", rd, 32'h00000088);
    apb(1'b0, fap_pkg::IDX_PF4_HI, 8'h00);
    chk("pf4_hi_rst", rd, 32'h00000088);
    apb(1'b1, fap_pkg::IDX_PF2_HI, 8'hFF);
    apb(1'b0, fap_pkg::IDX_PF2_HI, 8'h00);
    chk("pf2_hi_bit2", rd, 32'h000000FB);
    apb(1'b0, 16'hE628, 8'h00);
    chk("unmapped_err", {31'h0, err}, 32'h00000001);
  endtask
  task test_packets;
    apb(1'b1, fap_pkg::IDX_LEN_HI[0], 8'h00);
    apb(1'b1, fap_pkg::IDX_LEN_LO[0], 8'h04);
    apb(1'b1, fap_pkg::IDX_CTRL, 8'h01);
    slow <= 1'b1;
    send(2'h0, 8, beats + 8);
    chk("auto_lasts", 32'(lasts), 32'h00000002);
    chk("auto_end_byte", 32'(end_byte), 32'h00000007);
    apb(1'b1, fap_pkg::IDX_CTRL, 8'h00);
    slow <= 1'b0;
    send(2'h2, 6, beats + 6);
    chk("manual_lasts", 32'(lasts), 32'h00000002);
    chk("manual_ep", 32'(last_ep), 32'h00000002);
  endtask
  task set_flags(input logic [7:0] ctrl, input logic [15:0] hi_idx, input logic [7:0] hi,
                 input logic [7:0] lo);
    apb(1'b1, fap_pkg::IDX_CTRL, ctrl);
    apb(1'b1, hi_idx, hi);
    apb(1'b1, hi_idx + 16'h0001, lo);
    repeat (2) @(posedge ref_clk_in);
  endtask
  task test_flags;
    set_flags(8'h30, fap_pkg::IDX_PF2_HI, 8'hE8, 8'h00);
    chk("ep2_hs_packet_count_field", 32'(ep2_pk), 32'h00000005);
    chk("ep2_sel", 32'(ep2_sel), 32'h00000003);
    set_flags(8'h10, fap_pkg::IDX_PF2_HI, 8'h3B, 8'h00);
    chk("ep2_hs_out", 32'(ep2_cnt), 32'h00001F00);
    set_flags(8'h20, fap_pkg::IDX_PF2_HI, 8'h01, 8'h80);
    chk("ep2_fs_packet_count_field", 32'(ep2_pk), 32'h00000006);
    set_flags(8'h50, fap_pkg::IDX_PF4_HI, 8'hD8, 8'h00);
    chk("ep4_hs_packet_count_field", 32'(ep4_pk), 32'h00000003);
    chk("ep4_sel", 32'(ep4_sel), 32'h00000003);
    set_flags(8'h10, fap_pkg::IDX_PF4_HI, 8'h19, 8'hFF);
    chk("ep4_clamp", 32'(ep4_cnt), 32'h00000400);
  endtask
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    {psel, pen, pwr, sv, slow} = 5'h00;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    sdata = 8'h00;
    sep = 2'h0;
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    test_reset_map();
    test_packets();
    test_flags();
    finish_test();
  end
endmodule
